// *** src/udw_walker.sv ***
// How it works
// [RQ1] General descriptors serve interrupt, control, bulk; isochronous ones are refused here.
// [RQ2] A descriptor buffer may hold any length from 0 to 8192 bytes.
// [RQ3] The buffer may span two separate memory pages.
// [RQ4] Software appends by linking the tail descriptor, then moving the tail pointer.
// [RQ5] Descriptors are walked independently of processor activity on the queue.
// [RQ6] Software sets the skip flag before removing or switching a queue.
// [RQ7] Software places general descriptors on 16-byte granules.
// [RQ8] After an error-free packet the buffer pointer grows by bytes moved.
// [RQ9] A page crossing takes the upper 20 bits from the buffer end address.
// [RQ10] After crossing, work resumes at byte 0 of the final byte's page.
// [RQ11] Rounding clear: short final IN packet is an error; set: accepted.
// [RQ12] Token direction code is used only when the endpoint defers direction.
// [RQ13] Code 00 SETUP, 01 OUT, 10 IN, 11 reserved.
// [RQ14] Endpoint direction 01 is OUT, 10 is IN, 00 and 11 defer.
// [RQ15] A skipped endpoint moves on without reading the queue or sending tokens.
// [RQ16] Queue head equal to tail means empty; otherwise work is queued.
`timescale 1ns/10ps
module udw_walker (
  // Clock, reset, enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Endpoint descriptor fields, held while busy_o is high.
  input wire logic start_i,
  input wire logic ed_skip_i,
  input wire logic ed_iso_format_i,
  input wire logic [1:0] ed_dir_i,
  input wire logic [10:0] ed_max_packet_i,
  input wire logic [31:4] queue_head_pointer_i,
  input wire logic [31:4] queue_tail_pointer_i,
  // Transfer descriptor fields.
  input wire logic [31:0] td_cur_buf_i,
  input wire logic [31:0] td_buf_end_i,
  input wire logic td_rounding_i,
  input wire logic [1:0] token_direction_code_i,
  // Packet result from the link side.
  input wire logic pkt_end_i,
  input wire logic pkt_ok_i,
  // Byte stream into the staging FIFO.
  input wire logic in_valid_i,
  input wire logic [7:0] in_data_i,
  output logic in_ready_o,
  // Byte stream out of the staging FIFO.
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  input wire logic out_ready_i,
  // Status.
  output logic busy_o,
  output logic dir_in_o,
  output logic [1:0] token_pid_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] cur_buf_o,
  output logic [13:0] remaining_o,
  output logic next_ed_o,
  output logic done_o,
  output logic queue_empty_o,
  output logic iso_refused_o,
  output logic dir_err_o,
  output logic short_err_o
);
  udw_pkg::udw_state_t state;
  udw_pkg::udw_state_t next_state;
  logic [12:0] pkt_bytes;
  logic f_in_ready;
  logic f_out_valid;
  logic [7:0] f_out_data;
  logic [4:0] f_level;
  logic flush;

  // ---------------------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------------------
  // [RQ14] endpoint direction decode
  wire ed_defers = (ed_dir_i != udw_pkg::ED_DIR_OUT) && (ed_dir_i != udw_pkg::ED_DIR_IN);
  // [RQ12] deferred token choice
  wire [1:0] pid_sel = ed_defers ? token_direction_code_i
                     : (ed_dir_i == udw_pkg::ED_DIR_IN) ? udw_pkg::TOK_IN : udw_pkg::TOK_OUT;
  // [RQ13] reserved token code
  wire pid_bad = (pid_sel == udw_pkg::TOK_RSVD);
  // [RQ16] empty queue test
  wire q_empty = (queue_head_pointer_i == queue_tail_pointer_i);
  // [RQ3] length over two pages
  wire two_pages = (td_cur_buf_i[31:12] != td_buf_end_i[31:12]);
  wire [13:0] len_one = 14'(td_buf_end_i[11:0]) - 14'(td_cur_buf_i[11:0]) + 14'h0001;
  wire [13:0] len_two = 14'(udw_pkg::PAGE_SIZE) + len_one;
  // [RQ2] zero pointer means zero length
  wire [13:0] buf_len = (td_cur_buf_i == udw_pkg::PTR_RST) ? udw_pkg::LEN_RST : two_pages ? len_two : len_one;
  wire in_xfer = (state == udw_pkg::ST_XFER);
  // Memory side is the fill side for OUT/SETUP and the drain side for IN.
  wire in_beat = in_valid_i && in_ready_o;
  wire out_beat = out_valid_o && out_ready_i;
  wire mem_beat = dir_in_o ? out_beat : in_beat;
  wire link_beat = dir_in_o ? in_beat : out_beat;
  // A byte may arrive on the very edge that ends the packet, so it is counted in.
  wire [12:0] pkt_cnt = pkt_bytes + 13'(link_beat);
  wire pkt_short = dir_in_o && (pkt_cnt < 13'(ed_max_packet_i)) && (remaining_o != 14'(pkt_cnt));
  wire pkt_last = (14'(pkt_cnt) == remaining_o) || pkt_short;
  wire drained = (f_level == 5'h00) && !out_valid_o;
  wire f_push = in_beat && f_in_ready;
  wire f_pop = ce_i && f_out_valid && (!out_valid_o || out_ready_i) && !flush;
  assign flush = in_xfer && pkt_end_i && !pkt_ok_i && !dir_in_o;

  // [RQ9] page-crossing pointer step
  function automatic logic [31:0] udw_step(input logic [31:0] p, input logic [12:0] n, input logic [31:0] be);
    logic [12:0] ofs;
    ofs = 13'(p[11:0]) + n;
    // [RQ10] resume in the end page at the wrapped offset, byte zero for a one-byte step
    udw_step = ofs[12] ? {be[31:12], ofs[11:0]} : {p[31:12], ofs[11:0]};
  endfunction : udw_step

  // ---------------------------------------------------------------------------
  // Walker state machine
  // ---------------------------------------------------------------------------
  // Next state: skip beats empty, empty beats format, format beats direction.
  always_comb begin
    next_state = state;
    unique case (state)
      udw_pkg::ST_IDLE: if (start_i) next_state = udw_pkg::ST_CHECK;
      udw_pkg::ST_CHECK: begin
        if (ed_skip_i || q_empty || ed_iso_format_i || pid_bad || buf_len == udw_pkg::LEN_RST)
          next_state = udw_pkg::ST_DONE;
        else
          next_state = udw_pkg::ST_XFER;
      end
      udw_pkg::ST_XFER: if (pkt_end_i && pkt_ok_i && pkt_last) next_state = udw_pkg::ST_DRAIN;
      udw_pkg::ST_DRAIN: if (drained) next_state = udw_pkg::ST_DONE;
      udw_pkg::ST_DONE: next_state = udw_pkg::ST_IDLE;
      default: next_state = udw_pkg::ST_IDLE;
    endcase
  end

  // [RQ5] free-running walk
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) state <= udw_pkg::ST_IDLE;
    else if (ce_i) state <= next_state;
  end

  // Descriptor check outcome, reported for one cycle at the end of the walk.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      next_ed_o <= 1'b0;
      queue_empty_o <= 1'b0;
      iso_refused_o <= 1'b0;
      dir_err_o <= 1'b0;
      dir_in_o <= 1'b0;
      token_pid_o <= udw_pkg::TOK_SETUP;
    end else if (ce_i) begin
      // [RQ15] skip without queue access
      next_ed_o <= (state == udw_pkg::ST_CHECK) && ed_skip_i;
      queue_empty_o <= (state == udw_pkg::ST_CHECK) && !ed_skip_i && q_empty;
      // [RQ1] isochronous format refused
      iso_refused_o <= (state == udw_pkg::ST_CHECK) && !ed_skip_i && !q_empty && ed_iso_format_i;
      dir_err_o <= (state == udw_pkg::ST_CHECK) && !ed_skip_i && !q_empty && !ed_iso_format_i && pid_bad;
      if (state == udw_pkg::ST_CHECK && !ed_skip_i && !q_empty) begin
        token_pid_o <= pid_sel;
        dir_in_o <= (pid_sel == udw_pkg::TOK_IN);
      end
    end
  end

  // Busy and done markers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= (next_state != udw_pkg::ST_IDLE);
      done_o <= (next_state == udw_pkg::ST_DONE);
    end
  end

  // ---------------------------------------------------------------------------
  // Buffer pointers
  // ---------------------------------------------------------------------------
  // The memory pointer runs ahead byte by byte; the committed pointer moves only on good packets,
  // so a failed OUT packet can be retried from the committed point.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_addr_o <= udw_pkg::PTR_RST;
      cur_buf_o <= udw_pkg::PTR_RST;
      remaining_o <= udw_pkg::LEN_RST;
      pkt_bytes <= udw_pkg::PKT_RST;
      short_err_o <= 1'b0;
    end else if (ce_i) begin
      short_err_o <= 1'b0;
      if (state == udw_pkg::ST_CHECK) begin
        mem_addr_o <= td_cur_buf_i;
        cur_buf_o <= td_cur_buf_i;
        remaining_o <= buf_len;
        pkt_bytes <= udw_pkg::PKT_RST;
      end else if (in_xfer && pkt_end_i) begin
        pkt_bytes <= udw_pkg::PKT_RST;
        if (pkt_ok_i) begin
          // [RQ8] advance by bytes moved
          cur_buf_o <= udw_step(cur_buf_o, pkt_cnt, td_buf_end_i);
          remaining_o <= remaining_o - 14'(pkt_cnt);
          // [RQ11] rounding flag check
          short_err_o <= pkt_short && !td_rounding_i;
        end
        // A failed OUT packet refetches from the committed point; otherwise a beat on this edge still counts.
        if (!pkt_ok_i && !dir_in_o) mem_addr_o <= cur_buf_o;
        else if (mem_beat) mem_addr_o <= udw_step(mem_addr_o, 13'h0001, td_buf_end_i);
      end else if (in_xfer || state == udw_pkg::ST_DRAIN) begin
        if (link_beat && in_xfer) pkt_bytes <= pkt_bytes + 13'h0001;
        if (mem_beat) mem_addr_o <= udw_step(mem_addr_o, 13'h0001, td_buf_end_i);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Data path
  // ---------------------------------------------------------------------------
  // Fill-side ready is registered with two slots of slack so a byte taken on the cycle
  // it drops still finds room. OUT fetches stop once the buffer is fully staged.
  wire [31:0] fetch_next = in_beat ? udw_step(mem_addr_o, 13'h0001, td_buf_end_i) : mem_addr_o;
  wire fetch_room = dir_in_o || (fetch_next != udw_step(cur_buf_o, 13'(remaining_o), td_buf_end_i));
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) in_ready_o <= 1'b0;
    else if (ce_i) in_ready_o <= (next_state == udw_pkg::ST_XFER) && (f_level < 5'h0e) && fetch_room;
  end

  // Output stage keeps the drain side flopped.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= 8'h00;
    end else if (ce_i) begin
      if (flush) out_valid_o <= 1'b0;
      else if (!out_valid_o || out_ready_i) begin
        out_valid_o <= f_out_valid;
        out_data_o <= f_out_data;
      end
    end
  end

  udw_fifo #(.W(udw_pkg::DATA_W), .D(udw_pkg::FIFO_DEPTH), .AW(udw_pkg::FIFO_AW)) udw_fifo_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .flush_i(flush),
    .in_valid_i(f_push),
    .in_data_i(in_data_i),
    .in_ready_o(f_in_ready),
    .out_valid_o(f_out_valid),
    .out_data_o(f_out_data),
    .out_ready_i(f_pop),
    .level_o(f_level)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_check_skip;
    ce_i && state == udw_pkg::ST_CHECK && ed_skip_i;
  endsequence
  sequence s_check_empty;
    ce_i && state == udw_pkg::ST_CHECK && !ed_skip_i && q_empty;
  endsequence

  skip_moves_on_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ15]
    s_check_skip |=> next_ed_o && done_o && !in_ready_o && !out_valid_o)
    else $error("skipped endpoint did not move on cleanly");
  empty_queue_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ16]
    s_check_empty |=> queue_empty_o && done_o && !in_ready_o)
    else $error("empty queue was not reported");
  iso_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
    ce_i && state == udw_pkg::ST_CHECK && !ed_skip_i && !q_empty && ed_iso_format_i |=> iso_refused_o && done_o)
    else $error("isochronous descriptor not refused");
  ed_dir_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ14]
    ce_i && state == udw_pkg::ST_CHECK && !ed_skip_i && !q_empty && ed_dir_i == udw_pkg::ED_DIR_IN |=> dir_in_o)
    else $error("endpoint IN direction ignored");
  pid_use_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ12]
    ce_i && state == udw_pkg::ST_CHECK && !ed_skip_i && !q_empty && ed_dir_i == udw_pkg::ED_DIR_OUT
    |=> token_pid_o == udw_pkg::TOK_OUT)
    else $error("token code used although endpoint fixes direction");
  pid_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ13]
    ce_i && state == udw_pkg::ST_CHECK && !ed_skip_i && !q_empty && !ed_iso_format_i && ed_defers
    && token_direction_code_i == udw_pkg::TOK_RSVD |=> dir_err_o ##1 !busy_o)
    else $error("reserved token code accepted");
  ptr_adv_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    ce_i && in_xfer && pkt_end_i && pkt_ok_i && cur_buf_o[11:0] < 12'h0800 && pkt_cnt < 13'h0400
    |=> cur_buf_o == $past(cur_buf_o) + 32'($past(pkt_cnt)))
    else $error("buffer pointer not advanced by packet size");
  page_cross_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ9]
    ce_i && in_xfer && !pkt_end_i && mem_beat && mem_addr_o[11:0] == udw_pkg::PAGE_LAST
    |=> mem_addr_o == {td_buf_end_i[31:12], 12'h000})
    else $error("page crossing did not switch to the end page");
  short_pkt_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ11]
    ce_i && in_xfer && pkt_end_i && pkt_ok_i && pkt_short && td_rounding_i |=> !short_err_o)
    else $error("short packet flagged although rounding allowed");
  len_max_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
    busy_o |-> remaining_o <= udw_pkg::MAX_LEN)
    else $error("remaining count beyond buffer maximum");
endmodule : udw_walker

// *** src/udw_pkg.sv ***
package udw_pkg;
  // Data path widths and the staging FIFO.
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  // Byte count of one descriptor, up to 8192 bytes.
  localparam int LEN_W = 14;
  localparam logic [13:0] MAX_LEN = 14'h2000;
  // Page geometry: 4-K pages, upper 20 address bits name the page.
  localparam int PAGE_OFS_W = 12;
  localparam logic [11:0] PAGE_LAST = 12'h0fff;
  localparam logic [12:0] PAGE_SIZE = 13'h1000;
  // Endpoint direction field codes.
  localparam logic [1:0] ED_DIR_OUT = 2'h1;
  localparam logic [1:0] ED_DIR_IN = 2'h2;
  // Token direction codes of a transfer descriptor.
  localparam logic [1:0] TOK_SETUP = 2'h0;
  localparam logic [1:0] TOK_OUT = 2'h1;
  localparam logic [1:0] TOK_IN = 2'h2;
  localparam logic [1:0] TOK_RSVD = 2'h3;
  // Values after reset.
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam logic [13:0] LEN_RST = 14'h0000;
  localparam logic [12:0] PKT_RST = 13'h0000;
  // Walker states, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CHECK = 5'h02,
    ST_XFER = 5'h04,
    ST_DRAIN = 5'h08,
    ST_DONE = 5'h10
  } udw_state_t;
endpackage : udw_pkg

// *** src/udw_fifo.sv ***
`timescale 1ns/10ps
module udw_fifo #(
  parameter int W = 8,
  parameter int D = 16,
  parameter int AW = 4
) (
  // Clock, reset, enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic flush_i,
  // Fill side.
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side.
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i,
  // Fill level.
  output logic [AW:0] level_o
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  // Full and empty come straight from the level count.
  assign in_ready_o = (level_o != (AW + 1)'(D));
  assign out_valid_o = (level_o != '0);
  assign out_data_o = mem[rd_ptr];

  // Pointers and level; a flush drops whatever is stored.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level_o <= '0;
    end else if (ce_i) begin
      if (flush_i) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        level_o <= '0;
      end else begin
        if (push) wr_ptr <= wr_ptr + 1'b1;
        if (pop) rd_ptr <= rd_ptr + 1'b1;
        if (push && !pop) level_o <= level_o + 1'b1;
        else if (pop && !push) level_o <= level_o - 1'b1;
      end
    end
  end

  // Storage has no reset; only written slots are ever read.
  always_ff @(posedge clk_i) begin
    if (ce_i && push && !flush_i) mem[wr_ptr] <= in_data_i;
  end
endmodule : udw_fifo

// *** dv/udw_sink_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Far-side sink: takes the walker's outgoing byte stream
// ------------------------------------------------------------
module udw_sink_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Byte stream from the walker.
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  output logic ready_o,
  // Pacing: stall holds ready low, slow gives ready every other cycle.
  input wire logic stall_i,
  input wire logic slow_i
);
  logic [7:0] got [$];
  logic phase;

  // Ready changes only after an edge, so a beat is taken at the edge where both are high.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
      ready_o <= ~stall_i & (~slow_i | phase);
      if (valid_i === 1'b1 && ready_o) begin
        got.push_back(data_i);
      end
    end
  end
endmodule : udw_sink_model

// *** dv/usb_host_transfer_descriptor_walker_tb.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Walker testbench
// ------------------------------------------------------------
module usb_host_transfer_descriptor_walker_tb;
  logic clk_i, rst_i, start_i, ed_skip_i, ed_iso_format_i, td_rounding_i;
  logic pkt_end_i, pkt_ok_i, in_valid_i, stall, slow, in_ready_o, out_valid_o, out_ready_i, ce;
  logic busy_o, dir_in_o, next_ed_o, done_o, queue_empty_o, iso_refused_o, dir_err_o, short_err_o;
  logic [1:0] ed_dir_i, token_direction_code_i, token_pid_o;
  logic [10:0] ed_max_packet_i;
  logic [31:4] qh, qt;
  logic [31:0] td_cur_buf_i, td_buf_end_i, mem_addr_o, cur_buf_o;
  logic [7:0] in_data_i, out_data_o;
  logic [13:0] remaining_o;
  logic [4:0] seen;
  logic took;
  int err_count, check_count, cyc, sent, c;
  logic [4:0] ref_exp [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h02, 5'h00};
  logic [1:0] dir_t [5] = '{2'h0, 2'h3, 2'h1, 2'h0, 2'h2};
  logic [1:0] code_t [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
  logic [1:0] pid_t [5] = '{udw_pkg::TOK_SETUP, udw_pkg::TOK_OUT, udw_pkg::TOK_OUT, udw_pkg::TOK_IN, udw_pkg::TOK_IN};

  udw_walker udw_walker_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .start_i(start_i), .ed_skip_i(ed_skip_i),
    .ed_iso_format_i(ed_iso_format_i), .ed_dir_i(ed_dir_i), .ed_max_packet_i(ed_max_packet_i),
    .queue_head_pointer_i(qh), .queue_tail_pointer_i(qt), .td_cur_buf_i(td_cur_buf_i),
    .td_buf_end_i(td_buf_end_i), .td_rounding_i(td_rounding_i), .token_direction_code_i(token_direction_code_i),
    .pkt_end_i(pkt_end_i), .pkt_ok_i(pkt_ok_i), .in_valid_i(in_valid_i), .in_data_i(in_data_i),
    .in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i),
    .busy_o(busy_o), .dir_in_o(dir_in_o), .token_pid_o(token_pid_o), .mem_addr_o(mem_addr_o),
    .cur_buf_o(cur_buf_o), .remaining_o(remaining_o), .next_ed_o(next_ed_o), .done_o(done_o),
    .queue_empty_o(queue_empty_o), .iso_refused_o(iso_refused_o), .dir_err_o(dir_err_o), .short_err_o(short_err_o));

  udw_sink_model udw_sink_model_i (.clk_i(clk_i), .rst_i(rst_i), .valid_i(out_valid_o), .data_i(out_data_o),
    .ready_o(out_ready_i), .stall_i(stall), .slow_i(slow));

  // Clock of 40 ns period.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Pulses are gathered at the falling edge, where they have settled; the ceiling cuts a hang short.
  always @(negedge clk_i) begin
    seen <= seen | {next_ed_o, queue_empty_o, iso_refused_o, dir_err_o, short_err_o};
    took <= took | in_ready_o;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task tick;
    @(posedge clk_i);
    #1;
  endtask : tick

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task setd(input logic [1:0] dir, input logic [1:0] code, input logic [31:0] cb, input logic [31:0] be);
    ed_dir_i = dir;
    token_direction_code_i = code;
    td_cur_buf_i = cb;
    td_buf_end_i = be;
  endtask : setd

  task go;
    seen = 5'h00;
    took = 1'b0;
    start_i = 1'b1;
    tick();
    start_i = 1'b0;
    c = 0;
  endtask : go

  task finish_walk;
    while (done_o !== 1'b1 && c < 300) begin
      tick();
      c++;
    end
    chk(c < 300, 1'b1);
    tick();
  endtask : finish_walk

  // The last link byte of a packet carries the packet end and its status; when the bytes pushed are
  // memory bytes, the link end is pulsed once the sink has taken every byte of the packet.
  task push(input int n, input logic ok, input logic lnk);
    int base;
    base = udw_sink_model_i.got.size();
    for (int i = 0; i < n; i++) begin
      in_valid_i = 1'b1;
      in_data_i = 8'h40 + i[7:0];
      pkt_end_i = lnk && (i == n - 1);
      pkt_ok_i = ok;
      do @(posedge clk_i); while (in_ready_o !== 1'b1);
      #1;
      sent++;
    end
    in_valid_i = 1'b0;
    if (lnk) begin
      pkt_end_i = 1'b0;
    end else begin
      while (udw_sink_model_i.got.size() < base + n) tick();
      pkt_end_i = 1'b1;
      tick();
      pkt_end_i = 1'b0;
    end
  endtask : push

  task chk_data(input int n);
    chk(udw_sink_model_i.got.size(), n);
    for (int i = 0; i < n && i < udw_sink_model_i.got.size(); i++) begin
      chk(udw_sink_model_i.got[i], 8'h40 + i[7:0]);
    end
    udw_sink_model_i.got.delete();
  endtask : chk_data

  task conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    {rst_i, start_i, ed_skip_i, ed_iso_format_i, td_rounding_i, pkt_end_i, pkt_ok_i} = 7'h41;
    {in_valid_i, stall, slow, in_data_i} = 11'h000;
    ed_max_packet_i = 11'h040;
    ce = 1'b1;
    qh = 28'h000_0010;
    qt = 28'h000_0011;
    setd(2'h1, 2'h1, 32'h0000_1000, 32'h0000_1003);
    repeat (20) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    chk({busy_o, done_o}, 32'h0000_0000);
    chk(cur_buf_o, 32'h0000_0000);
    // early exits: skip, empty, isochronous, reserved code, zero length.
    for (int k = 0; k < 6; k++) begin
      ed_skip_i = (k == 0);
      ed_iso_format_i = (k == 2);
      qt = (k < 2) ? qh : qh + 28'h000_0001;
      setd((k == 4) ? 2'h3 : 2'h0, (k == 3 || k == 4) ? 2'h3 : 2'h0, (k == 5) ? 32'h0 : 32'h0000_1000,
        32'h0000_1003);
      go();
      if (k == 1) begin
        ce = 1'b0;
        repeat (3) tick();
        chk({busy_o, done_o, queue_empty_o}, 3'h4);
        ce = 1'b1;
      end
      finish_walk();
      chk(seen, ref_exp[k]);
      chk(c, 1);
      chk(took, 1'b0);
    end
    {ed_skip_i, ed_iso_format_i} = 2'h0;
    $display("early exit test done");
    // direction choice over every endpoint direction code, with a slow taker.
    slow = 1'b1;
    for (int k = 0; k < 5; k++) begin
      setd(dir_t[k], code_t[k], 32'h0000_1000, 32'h0000_1003);
      go();
      push(4, 1'b1, k > 2);
      finish_walk();
      chk(token_pid_o, pid_t[k]);
      chk(dir_in_o, k > 2);
      chk(remaining_o, 32'h0000_0000);
      chk(cur_buf_o, 32'h0000_1004);
      chk(mem_addr_o, 32'h0000_1004);
      chk(seen, 5'h00);
      chk_data(4);
    end
    slow = 1'b0;
    $display("direction test done");
    // page crossing while the FIFO fills against a stalled taker.
    setd(2'h1, 2'h1, 32'h0001_2ff0, 32'h0004_5007);
    stall = 1'b1;
    sent = 0;
    go();
    fork
      push(24, 1'b1, 1'b0);
      begin
        repeat (40) tick();
        chk(sent >= 14 && sent <= 17, 1'b1);
        stall = 1'b0;
      end
    join
    finish_walk();
    chk(cur_buf_o, 32'h0004_5008);
    chk(mem_addr_o, 32'h0004_5008);
    chk_data(24);
    $display("page crossing test done");
    // a failed packet leaves the pointer alone; the retry advances it.
    setd(2'h1, 2'h1, 32'h0000_0200, 32'h0000_0207);
    go();
    push(8, 1'b0, 1'b0);
    repeat (10) tick();
    chk(cur_buf_o, 32'h0000_0200);
    push(8, 1'b1, 1'b0);
    finish_walk();
    chk(cur_buf_o, 32'h0000_0208);
    udw_sink_model_i.got.delete();
    $display("retry test done");
    // short IN packet with rounding clear and set.
    ed_max_packet_i = 11'h010;
    for (int r = 0; r < 2; r++) begin
      td_rounding_i = r[0];
      setd(2'h2, 2'h2, 32'h0000_0100, 32'h0000_011f);
      go();
      push(5, 1'b1, 1'b1);
      finish_walk();
      chk(seen[0], !r[0]);
      chk(cur_buf_o, 32'h0000_0105);
      chk_data(5);
    end
    $display("short packet test done");
    conclude();
  end
endmodule : usb_host_transfer_descriptor_walker_tb
